// ### core/rtc_time_registers.sv
// time-keeping registers with serial peripheral port and oscillator monitor
`timescale 1ns/10ps

module rtc_time_registers #(
   parameter int OSC_TIMEOUT = rtc_pkg::OSC_TIMEOUT_CYC,
   parameter int XTAL_DIV = rtc_pkg::XTAL_PER_SECOND,
   parameter int STABLE_EDGES = rtc_pkg::XTAL_STABLE_EDGES
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic xtal_in_i,
   input wire logic spi_clk_i,
   input wire logic spi_ce_i,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe_o,
   input wire logic hour_12_mode_i,
   input wire logic [7:0] month_bcd_i,
   input wire logic [7:0] year_bcd_i,
   output logic osc_halt_flag_o,
   output logic day_carry_o
);

   localparam int TW = $clog2(OSC_TIMEOUT + 1);
   localparam int DW = $clog2(XTAL_DIV + 1);
   localparam int SW = $clog2(STABLE_EDGES + 1);
   localparam logic [TW-1:0] TO_LAST = TW'(OSC_TIMEOUT);
   localparam logic [DW-1:0] DIV_LAST = DW'(XTAL_DIV - 1);
   localparam logic [SW-1:0] STB_LAST = SW'(STABLE_EDGES);
   localparam logic [2:0] BIT_LAST = 3'(rtc_pkg::SPI_BITS - 1);

   // ******************************
   // functions
   // ******************************
   function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] last,
                                           input logic [7:0] first);
      if (v == last) begin
         return first;
      end else if (v[3:0] == rtc_pkg::BCD_NINE[3:0]) begin
         return {v[7:4] + 4'h1, 4'h0};
      end
      return v + 8'h01;
   endfunction : bcd_next

   function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
      logic leap;
      // bcd value divisible by 4: tens even with units 0/4/8, tens odd with units 2/6
      leap = (y[4] == 1'b0) ? (y[1:0] == 2'b00 && y[3:0] != 4'h0c) : (y[1:0] == 2'b10);
      if (m == rtc_pkg::MONTH_FEB) begin
         return leap ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
      end else if (m == rtc_pkg::MONTH_APR || m == rtc_pkg::MONTH_JUN ||
                   m == rtc_pkg::MONTH_SEP || m == rtc_pkg::MONTH_NOV) begin
         return rtc_pkg::DAYS_30;
      end
      return rtc_pkg::DAYS_31;
   endfunction : month_last

   // ******************************
   // reset release and pin synchronisers
   // ******************************
   logic rst_meta_ff;
   logic rst_n;
   logic [3:0] sync1_ff;
   logic [3:0] sync2_ff;
   logic [3:0] prev_ff;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n <= rst_meta_ff;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sync1_ff <= 4'h0;
         sync2_ff <= 4'h0;
         prev_ff <= 4'h0;
      end else begin
         sync1_ff <= {xtal_in_i, spi_clk_i, spi_ce_i, sdio_i};
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
      end
   end

   logic xtal_rise;
   logic sclk_rise;
   logic sclk_fall;
   logic ce;
   logic sdi;
   assign xtal_rise = sync2_ff[3] & ~prev_ff[3];
   assign sclk_rise = sync2_ff[2] & ~prev_ff[2];
   assign sclk_fall = ~sync2_ff[2] & prev_ff[2];
   assign ce = sync2_ff[1];
   assign sdi = sync2_ff[0];

   // ******************************
   // oscillator monitor and 1 Hz divider
   // ******************************
   logic [TW-1:0] to_cnt_ff, nxt_to_cnt;
   logic [SW-1:0] stb_cnt_ff, nxt_stb_cnt;
   logic [DW-1:0] div_cnt_ff, nxt_div_cnt;
   logic osc_run;
   logic tick;

   // a timeout rather than an edge count: a held pin never produces an edge
   always_comb begin
      nxt_to_cnt = xtal_rise ? '0 : (to_cnt_ff == TO_LAST ? to_cnt_ff : to_cnt_ff + 1'b1);
      nxt_stb_cnt = stb_cnt_ff;
      nxt_div_cnt = div_cnt_ff;
      tick = 1'b0;
      if (to_cnt_ff == TO_LAST) begin
         nxt_stb_cnt = '0;
         nxt_div_cnt = '0;
      end else if (xtal_rise) begin
         if (stb_cnt_ff != STB_LAST) begin
            nxt_stb_cnt = stb_cnt_ff + 1'b1;
         end else begin
            nxt_div_cnt = (div_cnt_ff == DIV_LAST) ? '0 : div_cnt_ff + 1'b1;
            tick = (div_cnt_ff == DIV_LAST);
         end
      end
   end

   assign osc_run = (stb_cnt_ff == STB_LAST) && (to_cnt_ff != TO_LAST);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         to_cnt_ff <= '0;
         stb_cnt_ff <= '0;
         div_cnt_ff <= '0;
      end else begin
         to_cnt_ff <= nxt_to_cnt;
         stb_cnt_ff <= nxt_stb_cnt;
         div_cnt_ff <= nxt_div_cnt;
      end
   end

   // ******************************
   // serial port
   // ******************************
   rtc_pkg::spi_state_t st_ff, nxt_st;
   logic [2:0] bit_cnt_ff, nxt_bit_cnt;
   logic [7:0] shin_ff, nxt_shin;
   logic [7:0] shout_ff, nxt_shout;
   logic [4:0] addr_ff, nxt_addr;
   logic rd_ff, nxt_rd;
   logic hold_ff, nxt_hold;
   logic [7:0] byte_in;
   logic byte_done;
   logic wr_en;
   logic [7:0] rd_data;
   rtc_pkg::clock_time_t tm_ff, nxt_tm;
   logic [7:0] scratch_ff, nxt_scratch;
   logic os_ff, nxt_os;
   logic load_q_ff;

   assign byte_in = {shin_ff[6:0], sdi};
   assign byte_done = ce && sclk_rise && bit_cnt_ff == BIT_LAST;
   assign wr_en = byte_done && st_ff == rtc_pkg::SPI_DATA && !rd_ff;

   always_comb begin
      case (addr_ff)
         rtc_pkg::ADDR_SCRATCH: rd_data = scratch_ff;
         rtc_pkg::ADDR_SECONDS: rd_data = {os_ff, tm_ff.seconds};
         rtc_pkg::ADDR_MINUTES: rd_data = {1'b0, tm_ff.minutes};
         rtc_pkg::ADDR_HOURS: rd_data = {2'b00, tm_ff.hours};
         rtc_pkg::ADDR_DAYS: rd_data = {2'b00, tm_ff.days};
         rtc_pkg::ADDR_WEEKDAY: rd_data = {5'h00, tm_ff.weekday};
         default: rd_data = 8'h00;
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_shin = shin_ff;
      nxt_shout = shout_ff;
      nxt_addr = addr_ff;
      nxt_rd = rd_ff;
      nxt_hold = hold_ff;
      if (!ce) begin
         nxt_st = rtc_pkg::SPI_IDLE;
         nxt_bit_cnt = 3'h0;
         nxt_hold = 1'b0;
      end else begin
         case (st_ff)
            rtc_pkg::SPI_IDLE: begin
               nxt_st = rtc_pkg::SPI_CMD;
            end
            rtc_pkg::SPI_CMD: begin
               if (sclk_rise) begin
                  nxt_shin = byte_in;
                  nxt_bit_cnt = bit_cnt_ff + 3'h1;
               end
               if (byte_done) begin
                  nxt_st = rtc_pkg::SPI_DATA;
                  nxt_rd = byte_in[rtc_pkg::CMD_RW_BIT];
                  nxt_addr = byte_in[4:0];
               end
            end
            rtc_pkg::SPI_DATA: begin
               if (sclk_rise) begin
                  nxt_shin = byte_in;
                  nxt_bit_cnt = bit_cnt_ff + 3'h1;
               end
               if (byte_done) begin
                  nxt_addr = addr_ff + 5'h01;
               end
               if (sclk_fall) begin
                  nxt_hold = 1'b0;
                  if (!hold_ff) begin
                     nxt_shout = {shout_ff[6:0], 1'b0};
                  end
               end
            end
            default: begin
               nxt_st = rtc_pkg::SPI_IDLE;
            end
         endcase
      end
      if (load_q_ff) begin
         nxt_shout = rd_data;
         nxt_hold = 1'b1;
      end
   end

   // reload one cycle after each byte boundary of a read access, when the address is current
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         load_q_ff <= 1'b0;
      end else begin
         load_q_ff <= byte_done && (st_ff == rtc_pkg::SPI_CMD ? byte_in[rtc_pkg::CMD_RW_BIT]
                                                                : rd_ff);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= rtc_pkg::SPI_IDLE;
         bit_cnt_ff <= 3'h0;
         shin_ff <= 8'h00;
         shout_ff <= 8'h00;
         addr_ff <= 5'h00;
         rd_ff <= 1'b0;
         hold_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         bit_cnt_ff <= nxt_bit_cnt;
         shin_ff <= nxt_shin;
         shout_ff <= nxt_shout;
         addr_ff <= nxt_addr;
         rd_ff <= nxt_rd;
         hold_ff <= nxt_hold;
      end
   end

   assign sdio_o = shout_ff[7];
   assign sdio_oe_o = ce && st_ff == rtc_pkg::SPI_DATA && rd_ff;

   // ******************************
   // time counters and registers
   // ******************************
   logic pend_ff, nxt_pend;
   logic carry_ff, nxt_carry;

   always_comb begin
      logic [7:0] v;
      logic [7:0] hr;
      v = 8'h00;
      hr = 8'h00;
      nxt_tm = tm_ff;
      nxt_scratch = scratch_ff;
      nxt_carry = 1'b0;
      nxt_pend = pend_ff | tick;
      if (!ce && pend_ff) begin
         nxt_pend = tick;
         v = bcd_next({1'b0, tm_ff.seconds}, rtc_pkg::LAST_SEC_MIN, rtc_pkg::FIRST_ZERO);
         nxt_tm.seconds = v[6:0];
         if (v == rtc_pkg::FIRST_ZERO) begin
            v = bcd_next({1'b0, tm_ff.minutes}, rtc_pkg::LAST_SEC_MIN, rtc_pkg::FIRST_ZERO);
            nxt_tm.minutes = v[6:0];
            if (v == rtc_pkg::FIRST_ZERO) begin
               if (hour_12_mode_i) begin
                  hr = {2'b00, tm_ff.hours} & rtc_pkg::MASK_HR12;
                  if (hr == rtc_pkg::HR12_ELEVEN) begin
                     nxt_tm.hours = {~tm_ff.hours[rtc_pkg::MERIDIEM_BIT],
                                     rtc_pkg::HR12_TWELVE[4:0]};
                  end else begin
                     v = bcd_next(hr, rtc_pkg::HR12_TWELVE, rtc_pkg::FIRST_HR12);
                     nxt_tm.hours = {tm_ff.hours[rtc_pkg::MERIDIEM_BIT], v[4:0]};
                  end
                  hr = {3'b000, nxt_tm.hours[4:0]};
               end else begin
                  hr = bcd_next({2'b00, tm_ff.hours}, rtc_pkg::LAST_HR24, rtc_pkg::FIRST_ZERO);
                  nxt_tm.hours = hr[5:0];
               end
               if ((hour_12_mode_i && hr == rtc_pkg::HR12_TWELVE &&
                    !nxt_tm.hours[rtc_pkg::MERIDIEM_BIT]) ||
                   (!hour_12_mode_i && hr == rtc_pkg::FIRST_ZERO)) begin
                  v = bcd_next({2'b00, tm_ff.days}, month_last(month_bcd_i, year_bcd_i),
                               rtc_pkg::FIRST_DAY);
                  nxt_tm.days = v[5:0];
                  nxt_carry = (v == rtc_pkg::FIRST_DAY);
                  v = bcd_next({5'h00, tm_ff.weekday}, rtc_pkg::LAST_WDAY,
                               rtc_pkg::FIRST_ZERO);
                  nxt_tm.weekday = v[2:0];
               end
            end
         end
      end
      if (wr_en) begin
         case (addr_ff)
            rtc_pkg::ADDR_SCRATCH: nxt_scratch = byte_in;
            rtc_pkg::ADDR_SECONDS: nxt_tm.seconds = byte_in[6:0];
            rtc_pkg::ADDR_MINUTES: nxt_tm.minutes = byte_in[6:0];
            rtc_pkg::ADDR_HOURS: nxt_tm.hours = byte_in[5:0];
            rtc_pkg::ADDR_DAYS: nxt_tm.days = byte_in[5:0];
            rtc_pkg::ADDR_WEEKDAY: nxt_tm.weekday = byte_in[2:0];
            default: nxt_scratch = scratch_ff;
         endcase
      end
      // stop wins over a host clear, so a dead oscillator reads back as one
      nxt_os = os_ff;
      if (wr_en && addr_ff == rtc_pkg::ADDR_SECONDS) begin
         nxt_os = byte_in[rtc_pkg::OS_BIT];
      end
      if (!osc_run) begin
         nxt_os = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tm_ff <= '{rtc_pkg::RST_SECONDS, rtc_pkg::RST_MINUTES, rtc_pkg::RST_HOURS,
                    rtc_pkg::RST_DAYS, rtc_pkg::RST_WEEKDAY};
         scratch_ff <= rtc_pkg::RST_SCRATCH;
         os_ff <= 1'b1;
         pend_ff <= 1'b0;
         carry_ff <= 1'b0;
      end else begin
         tm_ff <= nxt_tm;
         scratch_ff <= nxt_scratch;
         os_ff <= nxt_os;
         pend_ff <= nxt_pend;
         carry_ff <= nxt_carry;
      end
   end

   assign osc_halt_flag_o = os_ff;
   assign day_carry_o = carry_ff;

endmodule : rtc_time_registers

// ### include/rtc_pkg.sv
// shared constants and types of the time-keeping register block
package rtc_pkg;

   // ******************************
   // register addresses
   // ******************************
   localparam logic [4:0] ADDR_SCRATCH = 5'h03;
   localparam logic [4:0] ADDR_SECONDS = 5'h04;
   localparam logic [4:0] ADDR_MINUTES = 5'h05;
   localparam logic [4:0] ADDR_HOURS = 5'h06;
   localparam logic [4:0] ADDR_DAYS = 5'h07;
   localparam logic [4:0] ADDR_WEEKDAY = 5'h08;

   // ******************************
   // reset values
   // ******************************
   localparam logic [7:0] RST_SCRATCH = 8'h00;
   localparam logic [6:0] RST_SECONDS = 7'h00;
   localparam logic [6:0] RST_MINUTES = 7'h00;
   localparam logic [5:0] RST_HOURS = 6'h00;
   localparam logic [5:0] RST_DAYS = 6'h01;
   localparam logic [2:0] RST_WEEKDAY = 3'h6;

   // ******************************
   // field positions and masks
   // ******************************
   localparam int OS_BIT = 7;
   localparam int MERIDIEM_BIT = 5;
   localparam int CMD_RW_BIT = 7;
   localparam logic [7:0] MASK_SEC_MIN = 8'h7f;
   localparam logic [7:0] MASK_HR24 = 8'h3f;
   localparam logic [7:0] MASK_HR12 = 8'h1f;
   localparam logic [7:0] MASK_DAY = 8'h3f;
   localparam logic [7:0] MASK_WDAY = 8'h07;

   // ******************************
   // bcd limits
   // ******************************
   localparam logic [7:0] BCD_NINE = 8'h09;
   localparam logic [7:0] LAST_SEC_MIN = 8'h59;
   localparam logic [7:0] LAST_HR24 = 8'h23;
   localparam logic [7:0] HR12_ELEVEN = 8'h11;
   localparam logic [7:0] HR12_TWELVE = 8'h12;
   localparam logic [7:0] FIRST_HR12 = 8'h01;
   localparam logic [7:0] FIRST_ZERO = 8'h00;
   localparam logic [7:0] FIRST_DAY = 8'h01;
   localparam logic [7:0] LAST_WDAY = 8'h06;
   localparam logic [7:0] MONTH_FEB = 8'h02;
   localparam logic [7:0] MONTH_APR = 8'h04;
   localparam logic [7:0] MONTH_JUN = 8'h06;
   localparam logic [7:0] MONTH_SEP = 8'h09;
   localparam logic [7:0] MONTH_NOV = 8'h11;
   localparam logic [7:0] DAYS_28 = 8'h28;
   localparam logic [7:0] DAYS_29 = 8'h29;
   localparam logic [7:0] DAYS_30 = 8'h30;
   localparam logic [7:0] DAYS_31 = 8'h31;

   // ******************************
   // timing
   // ******************************
   localparam int CLK_PERIOD_NS = 8;
   localparam int OSC_TIMEOUT_NS = 100000;
   localparam int OSC_TIMEOUT_CYC = OSC_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int XTAL_PER_SECOND = 32768;
   localparam int XTAL_STABLE_EDGES = 4096;
   localparam int SPI_BITS = 8;

   // ******************************
   // types
   // ******************************
   typedef struct packed {
      logic [6:0] seconds;
      logic [6:0] minutes;
      logic [5:0] hours;
      logic [5:0] days;
      logic [2:0] weekday;
   } clock_time_t;

   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_CMD = 2'b01,
      SPI_DATA = 2'b10
   } spi_state_t;

endpackage : rtc_pkg

// ### tb/rtc_time_registers_props.sv
// assertion checker for the time-keeping register block
`timescale 1ns/10ps
module rtc_time_registers_props #(
   parameter int OSC_TIMEOUT = 100,
   parameter int STABLE_EDGES = 4
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic xtal_in_i,
   input wire logic spi_clk_i,
   input wire logic spi_ce_i,
   input wire logic sdio_i,
   input wire logic sdio_o,
   input wire logic sdio_oe_o,
   input wire logic hour_12_mode_i,
   input wire logic [7:0] month_bcd_i,
   input wire logic [7:0] year_bcd_i,
   input wire logic osc_halt_flag_o,
   input wire logic day_carry_o
);
   localparam logic [15:0] STOP_SEEN = 16'(OSC_TIMEOUT + 8);
   localparam logic [15:0] RUN_LIMIT = 16'(OSC_TIMEOUT + 4);
   logic [15:0] xcnt_ff, nxt_xcnt;
   logic [7:0] ecnt_ff, nxt_ecnt, cgap_ff, nxt_cgap;
   logic xprev_ff, nxt_xprev;

   // ************************
   // helper counters
   // ************************
   always_comb begin
      nxt_xprev = xtal_in_i;
      nxt_xcnt = (xcnt_ff == 16'hffff) ? xcnt_ff : xcnt_ff + 16'h0001;
      if (xtal_in_i != xprev_ff) begin
         nxt_xcnt = 16'h0000;
      end
      nxt_ecnt = ecnt_ff;
      if (xtal_in_i && !xprev_ff && ecnt_ff != 8'hff) begin
         nxt_ecnt = ecnt_ff + 8'h01;
      end
      nxt_cgap = (cgap_ff == 8'hff) ? cgap_ff : cgap_ff + 8'h01;
      if (spi_ce_i) begin
         nxt_cgap = 8'h00;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         xcnt_ff <= 16'h0000;
         ecnt_ff <= 8'h00;
         cgap_ff <= 8'hff;
         xprev_ff <= 1'b0;
      end else begin
         xcnt_ff <= nxt_xcnt;
         ecnt_ff <= nxt_ecnt;
         cgap_ff <= nxt_cgap;
         xprev_ff <= nxt_xprev;
      end
   end

   // ************************
   // properties
   // ************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_ce_idle;
      !spi_ce_i [*5];
   endsequence
   // the next byte is loaded about three cycles after its last rising edge
   sequence s_bit_held;
      $stable(sdio_o) [*2];
   endsequence

   a_flag_at_release: assert property ($rose(arst_n_i) |-> osc_halt_flag_o)
      else $error("flag low after reset release");
   a_flag_until_stable: assert property (ecnt_ff < STABLE_EDGES |-> osc_halt_flag_o)
      else $error("flag dropped before crystal was stable");
   a_flag_on_stop: assert property (xcnt_ff == STOP_SEEN |-> osc_halt_flag_o)
      else $error("flag not set after crystal stopped");
   a_clear_in_access: assert property ($fell(osc_halt_flag_o) |-> cgap_ff < 8'h08)
      else $error("flag cleared outside a host access");
   a_clear_needs_osc: assert property ($fell(osc_halt_flag_o) |->
      xcnt_ff < RUN_LIMIT && ecnt_ff >= STABLE_EDGES)
      else $error("flag cleared while crystal stopped");
   a_carry_blocked: assert property (spi_ce_i [*6] |-> !day_carry_o)
      else $error("day advanced during an access");
   a_carry_pulse: assert property (day_carry_o |=> !day_carry_o [*8])
      else $error("day carry longer than one cycle");
   a_oe_idle_low: assert property (s_ce_idle |-> !sdio_oe_o)
      else $error("data pin driven while deselected");
   a_oe_needs_ce: assert property ($rose(sdio_oe_o) |-> spi_ce_i)
      else $error("drive enabled without chip enable");
   a_read_bit_held: assert property (sdio_oe_o && $rose(spi_clk_i) |=> s_bit_held)
      else $error("read bit changed while serial clock high");
endmodule : rtc_time_registers_props

bind rtc_time_registers rtc_time_registers_props #(
   .OSC_TIMEOUT(OSC_TIMEOUT),
   .STABLE_EDGES(STABLE_EDGES)
) u_props (
   .clk_i(clk_i),
   .arst_n_i(arst_n_i),
   .xtal_in_i(xtal_in_i),
   .spi_clk_i(spi_clk_i),
   .spi_ce_i(spi_ce_i),
   .sdio_i(sdio_i),
   .sdio_o(sdio_o),
   .sdio_oe_o(sdio_oe_o),
   .hour_12_mode_i(hour_12_mode_i),
   .month_bcd_i(month_bcd_i),
   .year_bcd_i(year_bcd_i),
   .osc_halt_flag_o(osc_halt_flag_o),
   .day_carry_o(day_carry_o)
);

// ### tb/rtc_host_model.sv
// serial host model for the three-wire port of the clock block
`timescale 1ns/10ps
module rtc_host_model #(
   parameter int HALF = 6
) (
   input wire logic clk_i,
   input wire logic dev_sdio_i,
   input wire logic dev_oe_i,
   output logic spi_clk_o,
   output logic spi_ce_o,
   output logic sdio_o
);
   logic [7:0] buf_q [8];
   logic hbit;
   logic hen;

   // released wire shows the inverse bit, so a stale value never reads back
   assign sdio_o = dev_oe_i ? dev_sdio_i : (hen ? hbit : ~hbit);

   initial begin
      spi_clk_o = 1'b0;
      spi_ce_o = 1'b0;
      hbit = 1'b0;
      hen = 1'b0;
   end

   // whole access in one go, shorter than a second unless a long hold is given
   task automatic access(input logic rd, input logic [4:0] addr, input int n, input int hold);
      logic [7:0] cmd;
      cmd = {rd, 2'b00, addr};
      @(negedge clk_i);
      spi_ce_o = 1'b1;
      repeat (hold) @(negedge clk_i);
      for (int b = 0; b <= n; b++) begin
         for (int i = 7; i >= 0; i--) begin
            hen = (b == 0) || !rd;
            hbit = (b == 0) ? cmd[i] : buf_q[b - 1][i];
            repeat (HALF) @(negedge clk_i);
            spi_clk_o = 1'b1;
            if (b > 0 && rd) begin
               buf_q[b - 1][i] = dev_sdio_i;
            end
            repeat (HALF) @(negedge clk_i);
            spi_clk_o = 1'b0;
         end
      end
      hen = 1'b0;
      repeat (HALF) @(negedge clk_i);
      spi_ce_o = 1'b0;
      repeat (2 * HALF) @(negedge clk_i);
   endtask : access
endmodule : rtc_host_model

// ### tb/rtc_time_registers_tb.sv
// self-checking bench for the time-keeping register block
`timescale 1ns/10ps
module rtc_time_registers_tb;
   localparam int OSC_T = 100;
   logic clk_i, arst_n_i, xtal_in_i, xtal_run, hour_12_mode_i;
   logic [7:0] month_bcd_i, year_bcd_i;
   logic spi_clk, spi_ce, sdio_to_dev, sdio_o, sdio_oe_o, osc_halt_flag_o, day_carry_o;
   int fail_count;
   int check_count;
   int carry_count;

   always @(posedge clk_i) begin
      if (day_carry_o === 1'b1) begin
         carry_count++;
      end
   end

   rtc_time_registers #(
      .OSC_TIMEOUT(OSC_T),
      .XTAL_DIV(32),
      .STABLE_EDGES(4)
   ) dut (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .xtal_in_i(xtal_in_i),
      .spi_clk_i(spi_clk),
      .spi_ce_i(spi_ce),
      .sdio_i(sdio_to_dev),
      .sdio_o(sdio_o),
      .sdio_oe_o(sdio_oe_o),
      .hour_12_mode_i(hour_12_mode_i),
      .month_bcd_i(month_bcd_i),
      .year_bcd_i(year_bcd_i),
      .osc_halt_flag_o(osc_halt_flag_o),
      .day_carry_o(day_carry_o)
   );

   rtc_host_model host (
      .clk_i(clk_i),
      .dev_sdio_i(sdio_o),
      .dev_oe_i(sdio_oe_o),
      .spi_clk_o(spi_clk),
      .spi_ce_o(spi_ce),
      .sdio_o(sdio_to_dev)
   );

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // gated crystal, so a stopped oscillator can be faked
   initial begin
      xtal_in_i = 1'b0;
      forever begin
         repeat (20) @(negedge clk_i);
         if (xtal_run) begin
            xtal_in_i = ~xtal_in_i;
         end
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict

   // re-read from seconds until the seconds byte moves
   task automatic poll(input logic [7:0] val, input int n);
      int k;
      k = 0;
      do begin
         host.access(1'b1, 5'h04, n, 0);
         k++;
      end while (host.buf_q[0] === val && k < 40);
      if (k == 40) begin
         fail_count++;
         $display("ERROR t=%0t no tick seen", $time);
         print_verdict();
      end
   endtask : poll

   task automatic t_reset();
      host.access(1'b1, 5'h03, 6, 0);
      check(host.buf_q[0], 8'h00, "scratch");
      check(host.buf_q[1], 8'h80, "seconds");
      check(host.buf_q[2], 8'h00, "minutes");
      check(host.buf_q[3], 8'h00, "hours");
      check(host.buf_q[4], 8'h01, "days");
      check(host.buf_q[5], 8'h06, "weekday");
      $display("reset test done");
   endtask : t_reset

   task automatic t_scratch();
      foreach (host.buf_q[i]) begin
         host.buf_q[0] = 8'ha5 ^ 8'(i * 8'h3f);
         host.access(1'b0, 5'h03, 1, 0);
         host.buf_q[0] = 8'h00;
         host.access(1'b1, 5'h03, 1, 0);
         check(host.buf_q[0], 8'ha5 ^ 8'(i * 8'h3f), "scratch");
      end
      host.buf_q[0] = 8'hff;
      host.access(1'b0, 5'h1f, 1, 0);
      host.access(1'b1, 5'h1f, 1, 0);
      check(host.buf_q[0], 8'h00, "unmapped");
      $display("scratch test done");
   endtask : t_scratch

   task automatic t_osc();
      host.buf_q[0] = 8'h00;
      host.access(1'b0, 5'h04, 1, 0);
      host.access(1'b1, 5'h04, 1, 0);
      check(host.buf_q[0], 8'h80, "clear while stopped");
      xtal_run = 1'b1;
      repeat (60) @(negedge clk_i);
      check({7'h00, osc_halt_flag_o}, 8'h01, "flag at start-up");
      repeat (400) @(negedge clk_i);
      check({7'h00, osc_halt_flag_o}, 8'h01, "flag kept");
      host.buf_q[0] = 8'h00;
      host.access(1'b0, 5'h04, 1, 0);
      check({7'h00, osc_halt_flag_o}, 8'h00, "flag cleared");
      xtal_run = 1'b0;
      repeat (OSC_T + 40) @(negedge clk_i);
      check({7'h00, osc_halt_flag_o}, 8'h01, "flag on stop");
      xtal_run = 1'b1;
      repeat (400) @(negedge clk_i);
      $display("oscillator test done");
   endtask : t_osc

   // columns: mode, hours, day, month, year, weekday, then expected hours, day, weekday
   task automatic t_roll();
      logic [7:0] r [9][9];
      int c0;
      r = '{'{8'h0, 8'h23, 8'h28, 8'h02, 8'h24, 8'h6, 8'h00, 8'h29, 8'h0},
            '{8'h0, 8'h23, 8'h28, 8'h02, 8'h00, 8'h5, 8'h00, 8'h29, 8'h6},
            '{8'h0, 8'h23, 8'h28, 8'h02, 8'h23, 8'h0, 8'h00, 8'h01, 8'h1},
            '{8'h0, 8'h23, 8'h30, 8'h04, 8'h23, 8'h1, 8'h00, 8'h01, 8'h2},
            '{8'h0, 8'h23, 8'h30, 8'h12, 8'h23, 8'h2, 8'h00, 8'h31, 8'h3},
            '{8'h1, 8'h31, 8'h15, 8'h01, 8'h23, 8'h3, 8'h12, 8'h16, 8'h4},
            '{8'h1, 8'h11, 8'h15, 8'h01, 8'h23, 8'h4, 8'h32, 8'h15, 8'h4},
            '{8'h1, 8'h12, 8'h15, 8'h01, 8'h23, 8'h5, 8'h01, 8'h15, 8'h5},
            '{8'h0, 8'h09, 8'h15, 8'h01, 8'h23, 8'h6, 8'h10, 8'h15, 8'h6}};
      foreach (r[i]) begin
         hour_12_mode_i = r[i][0][0];
         month_bcd_i = r[i][3];
         year_bcd_i = r[i][4];
         host.buf_q[0] = 8'h59;
         host.buf_q[1] = 8'h59;
         host.buf_q[2] = r[i][1];
         host.buf_q[3] = r[i][2];
         host.buf_q[4] = r[i][5];
         c0 = carry_count;
         host.access(1'b0, 5'h04, 5, 0);
         poll(8'h59, 5);
         check(host.buf_q[0], 8'h00, "seconds wrap");
         check(host.buf_q[1], 8'h00, "minutes wrap");
         check(host.buf_q[2], r[i][6], "hours");
         check(host.buf_q[3], r[i][7], "day");
         check(host.buf_q[4], r[i][8], "weekday");
         check(8'(carry_count - c0), {7'h00, r[i][7] == 8'h01}, "day carry");
      end
      $display("rollover test done");
   endtask : t_roll

   // ce held over two ticks: value frozen, then only one tick caught up
   task automatic t_block();
      hour_12_mode_i = 1'b0;
      host.buf_q[0] = 8'h20;
      host.access(1'b0, 5'h04, 1, 0);
      poll(8'h20, 1);
      host.access(1'b1, 5'h04, 1, 3000);
      check(host.buf_q[0], 8'h21, "blocked seconds");
      host.access(1'b1, 5'h04, 1, 0);
      check(host.buf_q[0], 8'h22, "one pending tick");
      $display("blocking test done");
   endtask : t_block

   initial begin
      fail_count = 0;
      check_count = 0;
      carry_count = 0;
      arst_n_i = 1'b0;
      xtal_run = 1'b0;
      hour_12_mode_i = 1'b0;
      month_bcd_i = 8'h01;
      year_bcd_i = 8'h23;
      repeat (16) @(negedge clk_i);
      arst_n_i = 1'b1;
      repeat (8) @(negedge clk_i);
      t_reset();
      t_scratch();
      t_osc();
      t_roll();
      t_block();
      print_verdict();
   end
endmodule : rtc_time_registers_tb
